//--- src/move_literal_option_decode_pkg.sv
// constants and state layout for the move, literal and option decoder
package move_literal_option_decode_pkg;
  localparam int INSTR_WIDTH = 12;
  localparam int DATA_WIDTH = 8;
  localparam int FILE_ADDR_WIDTH = 5;
  localparam int FILE_COUNT = 32;
  localparam int FILE_ADDR_LSB = 0;
  localparam int DEST_BIT = 5;
  localparam int IMM_LSB = 0;
  localparam logic [11:0] MOVE_MASK = 12'hFC0;
  localparam logic [11:0] MOVE_PATTERN = 12'h200;
  localparam logic [11:0] STORE_MASK = 12'hFE0;
  localparam logic [11:0] STORE_PATTERN = 12'h020;
  localparam logic [11:0] IMM_MASK = 12'hF00;
  localparam logic [11:0] IMM_PATTERN = 12'hC00;
  localparam logic [11:0] OPTION_OPCODE_DEFAULT = 12'h002;
  localparam logic DEST_WORKING = 1'h0;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  typedef struct packed {
    logic [FILE_COUNT-1:0][DATA_WIDTH-1:0] files;
    logic [DATA_WIDTH-1:0] working;
    logic [DATA_WIDTH-1:0] option;
    logic zero;
    logic done;
    logic unknown;
    logic [DATA_WIDTH-1:0] rd_data;
  } exec_state_t;
endpackage : move_literal_option_decode_pkg

//--- src/move_literal_option_decode.sv
// executes file move, store, immediate load and option load instructions
// Summary of operation
// - a move from a file register goes to the working register when d is 0, else back to the file.
// - a file move sets the zero flag from the moved value and finishes in one cycle.
// - a store copies the working register into the addressed file, no flags, one cycle.
// - an immediate load puts the eight-bit field in the working register, no flags, one cycle.
// - the option load copies the working register into the option register, no flags, one cycle.
`timescale 1ns/1ps
module move_literal_option_decode #(
  parameter logic [11:0] OPTION_OPCODE = move_literal_option_decode_pkg::OPTION_OPCODE_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic instr_valid_in,
  input wire logic [move_literal_option_decode_pkg::INSTR_WIDTH-1:0] instr_in,
  input wire logic [move_literal_option_decode_pkg::FILE_ADDR_WIDTH-1:0] file_rd_addr_in,
  output logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] working_out,
  output logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] option_out,
  output logic zero_out,
  output logic done_out,
  output logic unknown_out,
  output logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] file_rd_data_out
);
  // instruction classes, one-hot
  typedef enum logic [5:0] {
    OP_IDLE = 6'h01,
    OP_MOVE = 6'h02,
    OP_STORE = 6'h04,
    OP_IMM = 6'h08,
    OP_OPTION = 6'h10,
    OP_OTHER = 6'h20
  } op_class_t;

  logic [1:0] rst_sync;
  logic rstn;
  move_literal_option_decode_pkg::exec_state_t state;
  move_literal_option_decode_pkg::exec_state_t next_state;

  // decoded operands
  logic [move_literal_option_decode_pkg::FILE_ADDR_WIDTH-1:0] addr;
  logic dest_file;
  logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] imm;
  logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] moved;

  // class match
  logic [move_literal_option_decode_pkg::INSTR_WIDTH-1:0] move_bits;
  logic [move_literal_option_decode_pkg::INSTR_WIDTH-1:0] store_bits;
  logic [move_literal_option_decode_pkg::INSTR_WIDTH-1:0] imm_bits;
  logic hit_move;
  logic hit_store;
  logic hit_imm;
  logic hit_option;

  op_class_t op_class;

  // write port controls
  logic file_we;
  logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] file_wdata;
  logic working_we;
  logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] working_wdata;
  logic option_we;
  logic zero_we;
  logic zero_wdata;
  logic group_hit;
  logic other_hit;
  logic [move_literal_option_decode_pkg::DATA_WIDTH-1:0] rd_next;

  // reset release
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rstn = rst_sync[1];

  // operand fields
  assign addr = instr_in[move_literal_option_decode_pkg::FILE_ADDR_LSB +:
    move_literal_option_decode_pkg::FILE_ADDR_WIDTH];
  assign dest_file = instr_in[move_literal_option_decode_pkg::DEST_BIT];
  assign imm = instr_in[move_literal_option_decode_pkg::IMM_LSB +:
    move_literal_option_decode_pkg::DATA_WIDTH];
  assign moved = state.files[addr];

  // class match per encoding
  assign move_bits = instr_in & move_literal_option_decode_pkg::MOVE_MASK;
  assign store_bits = instr_in & move_literal_option_decode_pkg::STORE_MASK;
  assign imm_bits = instr_in & move_literal_option_decode_pkg::IMM_MASK;
  assign hit_move = (move_bits ==
    move_literal_option_decode_pkg::MOVE_PATTERN);
  assign hit_store = (store_bits ==
    move_literal_option_decode_pkg::STORE_PATTERN);
  assign hit_imm = (imm_bits ==
    move_literal_option_decode_pkg::IMM_PATTERN);
  assign hit_option = (instr_in == OPTION_OPCODE);

  // one class per valid instruction, move first
  always_comb begin
    op_class = OP_IDLE;
    if (!instr_valid_in) begin
      op_class = OP_IDLE;
    end else if (hit_move) begin
      op_class = OP_MOVE;
    end else if (hit_store) begin
      op_class = OP_STORE;
    end else if (hit_imm) begin
      op_class = OP_IMM;
    end else if (hit_option) begin
      op_class = OP_OPTION;
    end else begin
      op_class = OP_OTHER;
    end
  end

  // write controls per class
  always_comb begin
    file_we = 1'h0;
    file_wdata = state.working;
    working_we = 1'h0;
    working_wdata = moved;
    option_we = 1'h0;
    zero_we = 1'h0;
    zero_wdata = 1'h0;
    group_hit = 1'h0;
    other_hit = 1'h0;

    case (op_class)
      // copy or test a file
      OP_MOVE: begin
        group_hit = 1'h1;
        zero_we = 1'h1;
        zero_wdata = (moved == move_literal_option_decode_pkg::DATA_ZERO);
        if (dest_file == move_literal_option_decode_pkg::DEST_WORKING) begin
          working_we = 1'h1;
          working_wdata = moved;
        end else begin
          file_we = 1'h1;
          file_wdata = moved;
        end
      end
      // working into a file, flags kept
      OP_STORE: begin
        group_hit = 1'h1;
        file_we = 1'h1;
        file_wdata = state.working;
      end
      // immediate into working, flags kept
      OP_IMM: begin
        group_hit = 1'h1;
        working_we = 1'h1;
        working_wdata = imm;
      end
      // working into option, flags kept
      OP_OPTION: begin
        group_hit = 1'h1;
        option_we = 1'h1;
      end
      OP_OTHER: begin
        other_hit = 1'h1;
      end
      OP_IDLE: begin
        group_hit = 1'h0;
      end
      default: begin
        group_hit = 1'h0;
      end
    endcase
  end

  // observed file after this edge's write
  always_comb begin
    rd_next = state.files[file_rd_addr_in];
    if (file_we && (file_rd_addr_in == addr)) begin
      rd_next = file_wdata;
    end
  end

  // next state from the write controls
  always_comb begin
    next_state = state;
    next_state.done = group_hit;
    next_state.unknown = other_hit;
    if (file_we) begin
      next_state.files[addr] = file_wdata;
    end
    if (working_we) begin
      next_state.working = working_wdata;
    end
    if (option_we) begin
      next_state.option = state.working;
    end
    if (zero_we) begin
      next_state.zero = zero_wdata;
    end
    next_state.rd_data = rd_next;
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      state.files <= {move_literal_option_decode_pkg::FILE_COUNT
        {move_literal_option_decode_pkg::FILE_RESET}};
      state.working <= move_literal_option_decode_pkg::WORKING_RESET;
      state.option <= move_literal_option_decode_pkg::OPTION_RESET;
      state.zero <= 1'h0;
      state.done <= 1'h0;
      state.unknown <= 1'h0;
      state.rd_data <= move_literal_option_decode_pkg::FILE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops
  assign working_out = state.working;
  assign option_out = state.option;
  assign zero_out = state.zero;
  assign done_out = state.done;
  assign unknown_out = state.unknown;
  assign file_rd_data_out = state.rd_data;
endmodule : move_literal_option_decode

//--- tb/decode_props.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module decode_props (
  input logic clk_sys_in,
  input logic rstn_in,
  input logic instr_valid_in,
  input logic [11:0] instr_in,
  input logic [4:0] file_rd_addr_in,
  input logic [7:0] working_out,
  input logic [7:0] option_out,
  input logic zero_out,
  input logic done_out,
  input logic unknown_out,
  input logic [7:0] file_rd_data_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire v = instr_valid_in;
  wire mv = v && instr_in[11:6] == 6'h08 && file_rd_addr_in == instr_in[4:0];
  wire st = v && instr_in[11:5] == 7'h01;
  a_move_work: assert property (mv && !instr_in[5]
  |=> working_out == $past(file_rd_data_out)) else $error("move to working wrong");
  a_move_zero: assert property (mv && instr_in[5]
  |=> zero_out == ($past(file_rd_data_out) == 8'h00)) else $error("zero flag wrong");
  a_zero_work: assert property (mv && !instr_in[5]
  |=> zero_out == ($past(file_rd_data_out) == 8'h00)) else $error("zero flag wrong");
  a_dest_file: assert property (mv && instr_in[5]
  |=> $stable(working_out) && file_rd_data_out == $past(file_rd_data_out))
  else $error("file destination wrong");
  a_store_quiet: assert property (st
  |=> $stable({zero_out, working_out}) && done_out) else $error("store touched flags");
  a_store_file: assert property (st && file_rd_addr_in == instr_in[4:0]
  |=> file_rd_data_out == $past(working_out)) else $error("store data wrong");
  a_imm_load: assert property (v && instr_in[11:8] == 4'hC
  |=> working_out == $past(instr_in[7:0]) && $stable(zero_out)) else $error("immediate wrong");
  a_opt_load: assert property (v && instr_in == 12'h002
  |=> option_out == $past(working_out) && $stable(zero_out)) else $error("option wrong");
  a_group_done: assert property (mv
  |=> done_out && !unknown_out) else $error("move not one cycle");
  a_other_refused: assert property (v && instr_in == 12'h000
  |=> unknown_out && !done_out && $stable({working_out, option_out, zero_out}))
  else $error("foreign instruction acted");
  a_idle_quiet: assert property (!v
  |=> !done_out && !unknown_out) else $error("pulse without instruction");
endmodule : decode_props
bind move_literal_option_decode decode_props u_props (
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .instr_valid_in(instr_valid_in),
  .instr_in(instr_in),
  .file_rd_addr_in(file_rd_addr_in),
  .working_out(working_out),
  .option_out(option_out),
  .zero_out(zero_out),
  .done_out(done_out),
  .unknown_out(unknown_out),
  .file_rd_data_out(file_rd_data_out)
);

//--- tb/tb_top.sv
// testbench for the move, literal and option decoder
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
$display("unexpected %0t value mismatch", $time); end end
module tb_top;
  logic clk_sys_in = 1'h0;
  logic rstn_in = 1'h0;
  logic instr_valid_in = 1'h0;
  logic [11:0] instr_in = 12'h000;
  logic [4:0] file_rd_addr_in = 5'h03;
  logic [7:0] working_out;
  logic [7:0] option_out;
  logic zero_out;
  logic done_out;
  logic unknown_out;
  logic [7:0] file_rd_data_out;
  int err_total = 0;
  int samples_checked = 0;

  move_literal_option_decode u_dut (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .file_rd_addr_in(file_rd_addr_in),
    .working_out(working_out),
    .option_out(option_out),
    .zero_out(zero_out),
    .done_out(done_out),
    .unknown_out(unknown_out),
    .file_rd_data_out(file_rd_data_out)
  );

  // one instruction, outputs settled on return
  task exec(input logic [11:0] i);
    @(posedge clk_sys_in) {instr_valid_in, instr_in} <= {1'h1, i};
    @(posedge clk_sys_in) instr_valid_in <= 1'h0;
    #1;
  endtask : exec

  // observed file changes a cycle before use
  task set_rd_addr(input logic [4:0] a);
    @(posedge clk_sys_in) file_rd_addr_in <= a;
  endtask : set_rd_addr

  task t_imm_store;
    exec(12'hC5A);
    `CHK(working_out, 8'h5A)
    `CHK(done_out, 1'h1)
    `CHK(unknown_out, 1'h0)
    exec(12'h023);
    `CHK(file_rd_data_out, 8'h5A)
    `CHK(working_out, 8'h5A)
    `CHK(done_out, 1'h1)
    $display("t_imm_store done");
  endtask : t_imm_store

  task t_move;
    exec(12'hC00);
    exec(12'h203);
    `CHK(working_out, 8'h5A)
    `CHK(zero_out, 1'h0)
    `CHK(done_out, 1'h1)
    exec(12'hC00);
    exec(12'h223);
    `CHK(file_rd_data_out, 8'h5A)
    `CHK(working_out, 8'h00)
    `CHK(zero_out, 1'h0)
    $display("t_move done");
  endtask : t_move

  task t_zero_flags;
    exec(12'h023);
    exec(12'h223);
    `CHK(zero_out, 1'h1)
    `CHK(file_rd_data_out, 8'h00)
    exec(12'hC33);
    `CHK(working_out, 8'h33)
    `CHK(zero_out, 1'h1)
    set_rd_addr(5'h1F);
    exec(12'h03F);
    `CHK(file_rd_data_out, 8'h33)
    `CHK(zero_out, 1'h1)
    exec(12'h002);
    `CHK(option_out, 8'h33)
    `CHK(zero_out, 1'h1)
    `CHK(done_out, 1'h1)
    exec(12'hC00);
    exec(12'h21F);
    `CHK(working_out, 8'h33)
    `CHK(zero_out, 1'h0)
    $display("t_zero_flags done");
  endtask : t_zero_flags

  task t_other;
    exec(12'h000);
    `CHK(unknown_out, 1'h1)
    `CHK(done_out, 1'h0)
    `CHK(working_out, 8'h33)
    `CHK(option_out, 8'h33)
    exec(12'h1FF);
    `CHK(unknown_out, 1'h1)
    `CHK(file_rd_data_out, 8'h33)
    @(posedge clk_sys_in);
    #1;
    `CHK(unknown_out, 1'h0)
    `CHK(done_out, 1'h0)
    $display("t_other done");
  endtask : t_other

  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  // scenarios need under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    err_total++;
    print_verdict;
  end

  initial begin
    repeat (8) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    @(posedge clk_sys_in);
    t_imm_store;
    t_move;
    t_zero_flags;
    t_other;
    print_verdict;
  end
endmodule : tb_top
